// >>> src/sel_loader.sv
// Serial EEPROM configuration loader with its write FIFO and register slave
`timescale 1ns/1ps

// ------------------------------------------------------------
// Write FIFO with a registered head
// ------------------------------------------------------------
module sel_fifo #(
	parameter int W     = 50,
	parameter int DEPTH = 32
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    ov;
		logic [W-1:0]            od;
	} sel_fifo_st_t;
	sel_fifo_st_t q, d;
	logic push, load;

	assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = q.ov;
	assign out_data  = q.od;

	// Head register refills whenever it is empty or being taken
	always_comb begin
		d    = q;
		push = in_valid && in_ready;
		load = (!q.ov || out_ready) && (q.cnt != '0);
		if (q.ov && out_ready)
			d.ov = 1'b0;
		if (load) begin
			d.od = q.mem[q.rp];
			d.ov = 1'b1;
			d.rp = q.rp + 1'b1;
		end
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp        = q.wp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end
endmodule

module sel_loader
	import sel_pkg::*;
#(
	parameter logic [15:0] EE_MODES   = 16'h0002,
	parameter logic [15:0] MAP_DWORDS = 16'h4000,
	parameter int          FIFO_DEPTH = 32
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         slow_bus_strap,
	input  wire logic [3:0]   switch_mode_strap,
	input  wire logic [3:0]   eeprom_addr_straps,
	input  wire logic         scl_i,
	output logic              scl_o,
	output logic              scl_oe,
	input  wire logic         sda_i,
	output logic              sda_o,
	output logic              sda_oe,
	output sel_pkg::sel_wr_t  cfg_wr,
	output logic              cfg_wr_valid,
	input  wire logic         cfg_wr_ready,
	output logic              init_hold,
	output logic              halt_after_reset_bit
);
	import sel_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  slow_s;
		logic [3:0]  mode_s1;
		logic [3:0]  mode_s2;
		logic [3:0]  addr_s1;
		logic [3:0]  addr_s2;
		logic [1:0]  sda_s;
		logic [1:0]  scl_s;
		logic [1:0]  settle;
		logic        pre_done;
		logic [7:0]  tcnt;
		sel_bst_t    bst;
		logic [1:0]  qph;
		logic [3:0]  bitn;
		logic [8:0]  sh;
		logic        sda_prev;
		logic        scl_oe;
		logic        sda_oe;
		sel_lst_t    lst;
		sel_pst_t    pst;
		logic        iss;
		logic        dummy;
		logic        probe;
		logic        single;
		logic        allff;
		logic [15:0] ptr;
		logic [15:0] addr;
		logic [15:0] cnt;
		logic [7:0]  sum;
		logic [8:0]  idx;
		logic [31:0] data;
		logic [1:0]  didx;
		logic [7:0]  ctl_pre;
		logic        ign;
		sel_stat_t   stat;
		sel_stat_t   err;
		logic        halt;
		logic        herr;
		logic        init_hold;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        aw_got;
		logic        w_got;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sel_state_t;

	sel_state_t q, d;
	logic       tick, eng_done, eng_nack, eng_frm, fifo_rdy, push_v, fin, ab;
	sel_bst_t   c_kind;
	logic [8:0] c_tx;
	logic [7:0] b;
	logic [7:0] sum_n;
	logic       allff_n;
	sel_wr_t    push_d;

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready        = q.awready;
	assign s_axi_wready         = q.wready;
	assign s_axi_bresp          = q.bresp;
	assign s_axi_bvalid         = q.bvalid;
	assign s_axi_arready        = q.arready;
	assign s_axi_rdata          = q.rdata;
	assign s_axi_rresp          = q.rresp;
	assign s_axi_rvalid         = q.rvalid;
	assign scl_o                = 1'b0;     // Open drain: only ever pulls low
	assign sda_o                = 1'b0;
	assign scl_oe               = q.scl_oe;
	assign sda_oe               = q.sda_oe;
	assign init_hold            = q.init_hold;
	assign halt_after_reset_bit = q.halt;

	// Register writes queue here so a slow target throttles the EEPROM reads
	sel_fifo #(.W($bits(sel_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (push_v),
		.in_ready  (fifo_rdy),
		.in_data   (push_d),
		.out_valid (cfg_wr_valid),
		.out_ready (cfg_wr_ready),
		.out_data  (cfg_wr)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		d        = q;
		eng_done = 1'b0;
		eng_nack = 1'b0;
		eng_frm  = 1'b0;
		push_v   = 1'b0;
		push_d   = '0;
		fin      = 1'b0;
		ab       = 1'b0;
		b        = q.sh[8:1];
		sum_n    = q.sum + b;
		allff_n  = q.allff && (b == BLANK_VAL);

		// Pin synchronisers
		d.slow_s  = {q.slow_s[0], slow_bus_strap};
		d.mode_s1 = switch_mode_strap;
		d.mode_s2 = q.mode_s1;
		d.addr_s1 = eeprom_addr_straps;
		d.addr_s2 = q.addr_s1;
		d.sda_s   = {q.sda_s[0], sda_i};
		d.scl_s   = {q.scl_s[0], scl_i};

		// Quarter-bit divider
		tick   = (q.tcnt == 8'h00);
		d.tcnt = tick ? q.ctl_pre - 8'h01 : q.tcnt - 8'h01;

		// Bit engine: each tick does the action of the current quarter
		if (tick && q.bst != B_IDLE) begin
			d.qph = q.qph + 2'h1;
			case (q.bst)
				B_START: begin
					case (q.qph)
						2'h0: d.sda_oe = 1'b0;
						2'h1: d.scl_oe = 1'b0;
						2'h2: d.sda_oe = 1'b1;
						default: begin
							d.scl_oe = 1'b1;
							d.bst    = B_IDLE;
							eng_done = 1'b1;
						end
					endcase
				end
				B_BIT: begin
					case (q.qph)
						2'h0: d.sda_oe = !q.sh[8];
						2'h1: d.scl_oe = 1'b0;
						2'h2: begin
							// Wait out a slave that stretches the clock
							if (q.scl_s[1]) begin
								d.sh       = {q.sh[7:0], q.sda_s[1]};
								d.sda_prev = q.sda_s[1];
							end else begin
								d.qph = q.qph;
							end
						end
						default: begin
							d.scl_oe = 1'b1;
							d.bitn   = q.bitn + 4'h1;
							// data moving under a high clock
							if (q.sda_s[1] != q.sda_prev) begin
								eng_frm  = 1'b1;
								eng_done = 1'b1;
								d.bst    = B_IDLE;
							end else if (q.bitn == 4'h8) begin
								eng_done = 1'b1;
								eng_nack = q.sh[0];
								d.bst    = B_IDLE;
							end
						end
					endcase
				end
				B_STOP: begin
					case (q.qph)
						2'h0: d.sda_oe = 1'b1;
						2'h1: d.scl_oe = 1'b0;
						2'h2: d.sda_oe = 1'b0;
						default: begin
							d.bst    = B_IDLE;
							eng_done = 1'b1;
						end
					endcase
				end
				default: d.bst = B_IDLE;
			endcase
		end

		// Register slave: software effects first so that hardware sets win
		if (q.awready && s_axi_awvalid) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (q.wready && s_axi_wvalid) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.aw_got && q.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = RESP_OKAY;
			case (sel_reg_sel(q.awaddr))
				RS_CTRL: begin
					if (q.wstrb[0])
						d.ctl_pre = q.wdata[7:0];
					if (q.wstrb[1])
						d.ign = q.wdata[CTRL_IGN_BIT];
				end
				RS_STAT: begin
					if (q.wstrb[0])
						d.stat = q.stat & ~sel_stat_t'(q.wdata[6:0]);
				end
				RS_SWITCH_CONTROL_REG: begin
					if (q.wstrb[0])
						d.halt = q.wdata[SWITCH_CONTROL_REG_HALT_BIT];
				end
				default: d.bresp = RESP_SLVERR;
			endcase
		end
		d.awready = !d.aw_got && !d.bvalid;
		d.wready  = !d.w_got && !d.bvalid;
		if (q.rvalid && s_axi_rready) begin
			d.rvalid  = 1'b0;
			d.arready = 1'b1;
		end
		if (q.arready && s_axi_arvalid) begin
			d.arready = 1'b0;
			d.rvalid  = 1'b1;
			d.rresp   = RESP_OKAY;
			case (sel_reg_sel(s_axi_araddr))
				RS_CTRL:  d.rdata = {23'h0, q.ign, q.ctl_pre};
				RS_STAT:  d.rdata = {25'h0, q.stat};
				RS_SWITCH_CONTROL_REG: d.rdata = {31'h0, q.halt};
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end

		// command each loader step hands to the bit engine
		c_kind = B_IDLE;
		c_tx   = 9'h1FF;
		case (q.lst)
			L_ST1, L_ST2: c_kind = B_START;
			L_SP:         c_kind = B_STOP;
			L_AH, L_AL: begin
				c_kind = B_BIT;
				c_tx   = 9'h001;
			end
			L_DW, L_DR: begin
				c_kind = B_BIT;
				// fixed high bits and address straps
				c_tx   = {sel_dev_byte(q.addr_s2, q.lst == L_DR), 1'b1};
			end
			L_RD: begin
				c_kind = B_BIT;
				// NACK the byte known to be the last one
				c_tx[0] = q.dummy || (q.ptr == PTR_LAST) ||
					(q.pst == P_CS && !q.allff && !q.probe);
			end
			default: c_kind = B_IDLE;
		endcase
		if (!q.iss && q.bst == B_IDLE && c_kind != B_IDLE && (q.lst != L_RD || fifo_rdy)) begin
			d.iss  = 1'b1;
			d.bst  = c_kind;
			d.qph  = 2'h0;
			d.bitn = 4'h0;
			d.sh   = c_tx;
		end

		// Loader sequence
		case (q.lst)
			L_STRAP: begin
				d.settle = q.settle + 2'h1;
				if (q.settle == 2'h3) begin
					d.pre_done = 1'b1;
					// bus rate from the slow-mode strap
					d.ctl_pre  = q.slow_s[1] ? PRE_SLOW : PRE_FAST;
					d.allff    = 1'b1;
					// skip the load in other modes
					if (EE_MODES[q.mode_s2]) begin
						d.lst = L_ST1;
					end else begin
						d.lst            = L_FIN;
						d.stat.finished  = 1'b1;
						d.init_hold      = 1'b0;
					end
				end
			end
			L_FIN: d.lst = L_FIN;
			default: begin
				if (q.iss && eng_done) begin
					d.iss = 1'b0;
					case (q.lst)
						L_ST1: d.lst = L_DW;
						L_ST2: d.lst = L_DR;
						L_DW, L_AH, L_AL, L_DR: begin
							if (eng_nack) begin
								d.err.nack = 1'b1;
								d.herr     = 1'b1;
								d.lst      = L_SP;
							end else begin
								d.lst = sel_lst_t'(q.lst + 4'h1);
							end
						end
						L_RD: begin
							if (q.dummy) begin
								fin = 1'b1;
							end else begin
								// walk the image byte by byte
								d.sum   = sum_n;
								d.ptr   = q.ptr + 16'h0001;
								d.allff = allff_n;
								if (q.idx != BLANK_SPAN)
									d.idx = q.idx + 9'h001;
								if (q.probe) begin
									if (b != BLANK_VAL) begin
										ab         = 1'b1;
										d.err.csum = !q.ign;
										d.herr     = !q.ign;
									end else if (q.idx == BLANK_SPAN - 9'h001) begin
										ab          = 1'b1;
										d.err.blank = 1'b1;
									end
								end else begin
									case (q.pst)
										P_TYPE: begin
											d.single = (b[7:6] == BT_SINGLE);
											d.didx   = 2'h0;
											case (b[7:6])
												BT_SINGLE, BT_SEQ: d.pst = P_A0;
												BT_DONE: d.pst = P_CS;
												default: begin
													ab         = 1'b1;
													d.err.csum = 1'b1;
													d.herr     = 1'b1;
												end
											endcase
										end
										P_A0: begin
											d.addr[7:0] = b;
											d.pst       = P_A1;
										end
										P_A1: begin
											d.addr[15:8] = b;
											d.pst        = q.single ? P_D : P_C0;
										end
										P_C0: begin
											d.cnt[7:0] = b;
											d.pst      = P_C1;
										end
										P_C1: begin
											d.cnt[15:8] = b;
											d.pst       = ({b, q.cnt[7:0]} == 16'h0000) ? P_TYPE : P_D;
										end
										P_D: begin
											// data bytes arrive least significant first
											d.data = {b, q.data[31:8]};
											d.didx = q.didx + 2'h1;
											if (q.didx == 2'h3) begin
												push_d.addr = {q.addr, 2'b00};
												push_d.data = {b, q.data[31:8]};
												if (q.addr < MAP_DWORDS)
													push_v = 1'b1;
												else
													d.err.unmapped = 1'b1;
												d.addr = q.addr + 16'h0001;
												d.cnt  = q.cnt - 16'h0001;
												if (q.single || q.cnt == 16'h0001)
													d.pst = P_TYPE;
											end
										end
										P_CS: begin
											// total including checksum must be all ones
											if (allff_n && q.idx != BLANK_SPAN - 9'h001) begin
												d.probe = 1'b1;
											end else begin
												d.err.csum = (sum_n != SUM_OK) && !q.ign;
												d.herr     = (sum_n != SUM_OK) && !q.ign;
												if (q.allff)
													ab = 1'b1;
												else
													fin = 1'b1;
											end
										end
										default: d.pst = P_TYPE;
									endcase
								end
								// the next read would wrap to zero
								if (!fin && q.ptr == PTR_LAST) begin
									d.err.rollover = 1'b1;
									d.herr         = 1'b1;
									fin            = 1'b1;
									ab             = 1'b0;
								end
							end
							// An aborted read still owes the slave a NACK
							if (fin)
								d.lst = L_SP;
							else if (ab)
								d.dummy = 1'b1;
						end
						L_SP: begin
							d.lst           = L_FIN;
							d.stat          = d.stat | q.err;
							d.stat.finished = 1'b1;
							d.halt          = d.halt | q.herr;
							d.init_hold     = 1'b0;
						end
						default: d.lst = L_FIN;
					endcase
					// misplaced START or STOP on the bus
					if (eng_frm && q.lst != L_SP) begin
						d.err.framing = 1'b1;
						d.herr        = 1'b1;
						d.lst         = L_SP;
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q           <= '0;
			q.init_hold <= 1'b1;
			q.awready   <= 1'b1;
			q.wready    <= 1'b1;
			q.arready   <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_stop_done;
		q.lst == L_SP ##1 q.lst == L_FIN;
	endsequence
	sequence s_strap_taken;
		$rose(q.pre_done);
	endsequence

	property p_prescale;
		s_strap_taken |-> q.ctl_pre == (q.slow_s[1] ? PRE_SLOW : PRE_FAST);
	endproperty
	a_prescale: assert property (p_prescale) else $error("bad prescale");
	property p_skip;
		s_strap_taken and !EE_MODES[q.mode_s2] |-> q.lst == L_FIN && !q.init_hold;
	endproperty
	a_skip: assert property (p_skip) else $error("load not skipped");
	property p_devaddr;
		q.lst == L_DW && q.bst == B_BIT && q.bitn == 4'h0 && q.qph == 2'h0
			|-> q.sh[8:1] == {DEV_FIXED, q.addr_s2, 1'b0};
	endproperty
	a_devaddr: assert property (p_devaddr) else $error("bad device address");
	property p_rollover;
		$rose(q.stat.rollover) |-> q.halt && q.stat.finished;
	endproperty
	a_rollover: assert property (p_rollover) else $error("rollover not halted");
	property p_blank;
		$rose(q.stat.blank) |-> !q.stat.csum && !$rose(q.halt) && q.stat.finished;
	endproperty
	a_blank: assert property (p_blank) else $error("blank mishandled");
	property p_push;
		push_v |-> push_d.addr[1:0] == 2'b00 && q.didx == 2'h3;
	endproperty
	a_push: assert property (p_push) else $error("bad register write");
	property p_unmapped;
		$rose(q.err.unmapped) |-> !$past(push_v);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped write issued");
	property p_csum;
		$rose(q.stat.csum) |-> q.halt;
	endproperty
	a_csum: assert property (p_csum) else $error("checksum error not halted");
	property p_nack;
		q.iss && eng_done && eng_nack && q.lst == L_DW |=> q.lst == L_SP ##[1:200] q.lst == L_FIN;
	endproperty
	a_nack: assert property (p_nack) else $error("nack not aborted");
	property p_fin;
		s_stop_done |-> q.stat.finished && !q.init_hold;
	endproperty
	a_fin: assert property (p_fin) else $error("finish not flagged");
	property p_hold;
		$fell(q.init_hold) |-> q.stat.finished && q.lst == L_FIN;
	endproperty
	a_hold: assert property (p_hold) else $error("init released early");
endmodule

// >>> src/sel_pkg.sv
// Package for the serial EEPROM configuration loader: constants, types and helpers
package sel_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ  = 10_000_000;
	localparam int SLOW_HZ = 100_000;
	localparam int FAST_HZ = 400_000;
	// Quarter-bit lengths in core cycles, rounded up so the bus never runs too fast
	localparam logic [7:0] PRE_SLOW = 8'((CLK_HZ + 4 * SLOW_HZ - 1) / (4 * SLOW_HZ));
	localparam logic [7:0] PRE_FAST = 8'((CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_SWITCH_CONTROL_REG = 8'h08;
	localparam int CTRL_IGN_BIT  = 8;
	localparam int SWITCH_CONTROL_REG_HALT_BIT = 0;
	localparam logic [1:0] RS_NONE  = 2'h0;
	localparam logic [1:0] RS_CTRL  = 2'h1;
	localparam logic [1:0] RS_STAT  = 2'h2;
	localparam logic [1:0] RS_SWITCH_CONTROL_REG = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Image format
	// ------------------------------------------------------------
	localparam logic [2:0]  DEV_FIXED  = 3'h5;
	localparam logic [1:0]  BT_SINGLE  = 2'h0;
	localparam logic [1:0]  BT_SEQ     = 2'h1;
	localparam logic [1:0]  BT_BAD     = 2'h2;
	localparam logic [1:0]  BT_DONE    = 2'h3;
	localparam logic [7:0]  SUM_OK     = 8'hFF;
	localparam logic [7:0]  BLANK_VAL  = 8'hFF;
	localparam logic [8:0]  BLANK_SPAN = 9'h100;
	localparam logic [15:0] PTR_LAST   = 16'hFFFF;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [17:0] addr;
		logic [31:0] data;
	} sel_wr_t;

	typedef struct packed {
		logic unmapped;
		logic blank;
		logic rollover;
		logic csum;
		logic framing;
		logic nack;
		logic finished;
	} sel_stat_t;

	typedef enum logic [1:0] {
		B_IDLE  = 2'b00,
		B_START = 2'b01,
		B_BIT   = 2'b10,
		B_STOP  = 2'b11
	} sel_bst_t;

	typedef enum logic [3:0] {
		L_STRAP = 4'b0000,
		L_ST1   = 4'b0001,
		L_DW    = 4'b0010,
		L_AH    = 4'b0011,
		L_AL    = 4'b0100,
		L_ST2   = 4'b0101,
		L_DR    = 4'b0110,
		L_RD    = 4'b0111,
		L_SP    = 4'b1000,
		L_FIN   = 4'b1001
	} sel_lst_t;

	typedef enum logic [2:0] {
		P_TYPE = 3'b000,
		P_A0   = 3'b001,
		P_A1   = 3'b010,
		P_C0   = 3'b011,
		P_C1   = 3'b100,
		P_D    = 3'b101,
		P_CS   = 3'b110
	} sel_pst_t;

	// Bus address byte of the EEPROM with the direction bit below
	function automatic logic [7:0] sel_dev_byte(input logic [3:0] straps, input logic rd);
		sel_dev_byte = {DEV_FIXED, straps, rd};
	endfunction

	// Which register a bus address selects
	function automatic logic [1:0] sel_reg_sel(input logic [7:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		if (w == OFS_CTRL)
			sel_reg_sel = RS_CTRL;
		else if (w == OFS_STAT)
			sel_reg_sel = RS_STAT;
		else if (w == OFS_SWITCH_CONTROL_REG)
			sel_reg_sel = RS_SWITCH_CONTROL_REG;
		else
			sel_reg_sel = RS_NONE;
	endfunction

endpackage

// >>> verification/sel_ee_model.sv
// Behavioural serial EEPROM slave on the open-drain bus
`timescale 1ns/1ps
module sel_ee_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [6:0] dev,
	output logic            pull
);
	logic [7:0]  mem [256];
	logic [7:0]  sh;
	logic [15:0] ptr;
	logic        rd;
	int          n;
	int          st;
	int          starts;
	initial begin
		pull = 0;
		st = 9;
	end
	// Start and stop are data edges while the clock is high
	always @(negedge sda) if (scl) begin
		n = 0;
		st = 0;
		rd = 0;
		starts++;
	end
	always @(posedge sda) if (scl) st = 9;
	// shift in, quit on master NACK
	always @(posedge scl) if (st < 9) begin
		if (rd && n == 8 && sda) st = 9;
		sh = {sh[6:0], sda};
		n++;
	end
	always @(negedge scl) if (st < 9) begin
		if (n == 9) n = 0;
		pull = 0;
		if (rd && n < 8) pull = ~mem[ptr[7:0]][7-n];
		else if (rd) ptr++;
		else if (n == 8 && (st > 0 || sh[7:1] == dev)) begin
			pull = 1;
			if (st == 0) rd = sh[0];
			if (st == 1) ptr[15:8] = sh;
			if (st == 2) ptr[7:0] = sh;
			st++;
		end
	end
endmodule

// >>> verification/smbus_eeprom_config_loader_bench.sv
// Self-checking bench for the serial EEPROM configuration loader
`timescale 1ns/1ps
module smbus_eeprom_config_loader_bench;
	import sel_pkg::*;
	logic [7:0]  awaddr, araddr, sum;
	logic [31:0] wdata, rdata, seed, v;
	logic [1:0]  bresp, rresp, r;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
	logic        arready, rvalid, rready, slow, scl_oe, sda_oe, pull, wr_valid, wr_ready;
	logic        hold, halt, stall, bad;
	logic [3:0]  mode, adr;
	logic [15:0] p;
	logic [49:0] d;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe | pull);
	sel_wr_t     wr, q[$];
	int          n_fail, checked, cyc, k;
	sel_loader #(.EE_MODES(16'h0002), .MAP_DWORDS(16'h4000), .FIFO_DEPTH(32)) sel_loader_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.slow_bus_strap(slow), .switch_mode_strap(mode), .eeprom_addr_straps(adr),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.cfg_wr(wr), .cfg_wr_valid(wr_valid), .cfg_wr_ready(wr_ready), .init_hold(hold),
		.halt_after_reset_bit(halt));
	// model answers only its strap address
	// A set bad flag moves the model off the strap address so the device byte is refused
	sel_ee_model ee (.scl(scl), .sda(sda), .dev({3'h5, adr ^ {3'h0, bad}}), .pull(pull));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		xs = s ^ (s << 5);
	endfunction
	task automatic end_of_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [49:0] g, input logic [49:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Image bytes, running sum kept for the checksum byte
	task automatic put(input logic [7:0] b);
		ee.mem[k] = b;
		sum += b;
		k++;
	endtask
	task automatic dw(input logic [15:0] a, input logic [31:0] x);
		for (int i = 0; i < 4; i++) put(x[8*i +: 8]);
		if (a < 16'h4000) q.push_back({a, 2'b00, x});
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] x);
		awaddr <= a;
		wdata <= x;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 0;
	endtask
	task automatic axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		d = {16'h0, rresp, rdata};
		rready <= 0;
	endtask
	task automatic rst(input logic s, input logic [3:0] m);
		slow <= s;
		mode <= m;
		adr <= v[3:0];
		aresetn <= 0;
		ee.starts = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		// Straps are taken on the fourth edge after release
		repeat (5) @(posedge aclk);
	endtask
	task automatic fin(input int t);
		do @(posedge aclk); while (hold || q.size() > 0);
		$display("test %0d done", t);
	endtask
	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	// Write stream: random stalls, each taken write checked in order
	always @(posedge aclk) begin
		cyc++;
		seed <= xs(seed);
		wr_ready <= !stall & seed[0];
		if (wr_valid && wr_ready) chk(50'(wr), 50'(q.pop_front()));
		if (cyc > 60000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} <= '0;
		{aresetn, slow, mode, adr, wr_ready, bad} <= '0;
		stall <= 1;
		seed = 32'h9F14;
		v = xs(seed);
		rst(1, 4'h0);
		fin(1);
		axr(OFS_CTRL);
		chk(d, 50'(PRE_SLOW));
		chk(50'(ee.starts), 50'h0);
		k = 0;
		sum = 0;
		put(8'h00);
		put(v[7:0]);
		put({2'b00, v[13:8]});
		dw({2'b00, v[13:0]}, xs(v));
		// Sequential block: addresses count up from its own start
		p = {8'h00, v[15:8]};
		put(8'h40);
		put(p[7:0]);
		put(8'h00);
		put(8'd36);
		put(8'h00);
		for (int i = 0; i < 36; i++) begin
			v = xs(v);
			dw(p + 16'(i), v);
		end
		put(8'h00);
		put(8'h00);
		put(8'h40);
		dw(16'h4000, v);
		put(8'hC0);
		put(~sum);
		rst(0, 4'h1);
		axr(OFS_CTRL);
		chk(d, 50'(PRE_FAST));
		axw(OFS_CTRL, 32'h2);
		chk(50'(r), 50'(RESP_OKAY));
		do begin
			p = ee.ptr;
			repeat (500) @(posedge aclk);
		end while (ee.ptr != p);
		chk(50'(hold), 50'h1);
		chk(50'(ee.ptr < 16'(k)), 50'h1);
		stall <= 0;
		fin(2);
		axr(OFS_STAT);
		chk(d, 50'h41);
		chk(50'(halt), 50'h0);
		axw(OFS_STAT, 32'h7F);
		axr(OFS_STAT);
		chk(d, 50'h0);
		axr(8'h10);
		chk(d, {16'h0, RESP_SLVERR, 32'h0});
		k = 0;
		put(8'h80);
		put(8'h00);
		rst(0, 4'h1);
		fin(3);
		axr(OFS_STAT);
		chk(d, 50'h09);
		chk(50'(halt), 50'h1);
		bad <= 1;
		rst(0, 4'h1);
		fin(4);
		axr(OFS_STAT);
		chk(d, 50'h03);
		chk(50'(halt), 50'h1);
		end_of_test();
	end
endmodule
